// ---- hw/iqc_queue_config.v ----
// queue configuration part of the global command register
`timescale 1ns/10ps
`include "iqc_consts.vh"
module iqc_queue_config (
	input wire CLK_SYS, // core clock 125 MHz
	input wire RST_N, // synchronous reset, active low
	input wire REG_WR, // register write strobe
	input wire [7:0] REG_ADDR, // register byte offset
	input wire [31:0] REG_WDATA, // write data
	output reg [31:0] REG_RDATA, // read data, command register view
	input wire [31:0] BASE_RX0, // rx queue 0 base address
	input wire [31:0] BASE_RX1, // rx queue 1 base address
	input wire [31:0] BASE_RX2, // rx queue 2 base address
	input wire [31:0] BASE_RX3, // rx queue 3 base address
	input wire [31:0] BASE_TX0, // tx queue 0 base address
	input wire [31:0] BASE_TX1, // tx queue 1 base address
	input wire [31:0] BASE_TX2, // tx queue 2 base address
	input wire [31:0] BASE_TX3, // tx queue 3 base address
	input wire [31:0] BASE_CFG, // config queue base address
	input wire [7:0] QLEN_RX, // rx queue length, all channels
	input wire [7:0] QLEN_TX, // tx queue length, all channels
	input wire [7:0] QLEN_CFG, // config queue length
	input wire [3:0] RX_VEC_VALID, // receiver vector strobe per channel
	input wire [3:0] TX_VEC_VALID, // transmitter vector strobe per channel
	input wire [127:0] RX_VEC, // receiver vectors, 32 bits per channel
	input wire [127:0] TX_VEC, // transmitter vectors, 32 bits per channel
	output reg VEC_WR, // vector write pulse
	output reg [31:0] VEC_ADDR, // vector write address
	output reg [31:0] VEC_DATA, // vector write data
	output reg CFG_BUSY, // configuration in progress
	output reg [8:0] Q_READY // queue configured flags
);
	localparam ST_IDLE = 2'd0;
	localparam ST_LOAD = 2'd1;
	localparam ST_ACK = 2'd2;

	reg [31:0] cmd_q;
	reg [8:0] sel_q;
	reg [1:0] st_q;
	reg [3:0] qi_q;
	reg [31:0] base_q [0:8];
	reg [7:0] len_q [0:8];
	reg [7:0] wp_q [0:8];
	reg [3:0] arb_q;
	reg fail_q;
	integer i;

	function [31:0] base_of;
		input [3:0] q;
		begin
			case (q)
			4'd0: base_of = BASE_RX0;
			4'd1: base_of = BASE_RX1;
			4'd2: base_of = BASE_RX2;
			4'd3: base_of = BASE_RX3;
			4'd4: base_of = BASE_TX0;
			4'd5: base_of = BASE_TX1;
			4'd6: base_of = BASE_TX2;
			4'd7: base_of = BASE_TX3;
			default: base_of = BASE_CFG;
			endcase
		end
	endfunction

	function [7:0] len_of;
		input [3:0] q;
		begin
			if (q < 4'd4)
				len_of = QLEN_RX;
			else if (q < 4'd8)
				len_of = QLEN_TX;
			else
				len_of = QLEN_CFG;
		end
	endfunction

	// queue index 0..3 rx ch0..3, 4..7 tx ch0..3, 8 config
	function [8:0] sel_of;
		input [31:0] w;
		begin
			sel_of = {w[`IQC_BIT_CFG_SEL],
				w[`IQC_BIT_TX_HI:`IQC_BIT_TX_LO],
				w[`IQC_BIT_RX_HI:`IQC_BIT_RX_LO]};
		end
	endfunction

	// write pointer wraps at the queue length, a ring of entries
	function [7:0] wp_next;
		input [7:0] wp;
		input [7:0] len;
		begin
			if (wp + 8'd1 >= len)
				wp_next = 8'h00;
			else
				wp_next = wp + 8'd1;
		end
	endfunction

	wire [8:0] sel_wr = sel_of(REG_WDATA);
	wire cmd_wr = REG_WR && REG_ADDR == `IQC_OFF_GLOBAL_COMMAND;
	wire ar_go = cmd_wr && REG_WDATA[`IQC_BIT_ACTION] && st_q == ST_IDLE;

	// per source: its vector word and whether its own queue can take it
	wire [3:0] src = arb_q;
	wire [31:0] src_word [0:7];
	wire [7:0] src_ok;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_src
			if (g < 4) begin : g_rx
				assign src_word[g] = RX_VEC[g*32 +: 32];
				assign src_ok[g] = RX_VEC_VALID[g] && Q_READY[g];
			end else begin : g_tx
				assign src_word[g] = TX_VEC[(g-4)*32 +: 32];
				assign src_ok[g] = TX_VEC_VALID[g-4] && Q_READY[g];
			end
		end
	endgenerate
	wire src_hit = src_ok[src[2:0]];
	wire [31:0] src_vec = src_word[src[2:0]];

	// next vector write: ack or fail while finishing, a pending source only when idle
	reg vec_wr_d;
	reg [31:0] vec_addr_d;
	reg [31:0] vec_data_d;
	always @* begin
		vec_wr_d = 1'b0;
		vec_addr_d = base_q[src] + {22'h0, wp_q[src], 2'b00};
		vec_data_d = src_vec;
		case (st_q)
		ST_IDLE: vec_wr_d = src_hit;
		ST_ACK: begin
			vec_wr_d = Q_READY[`IQC_CFG_Q];
			vec_addr_d = base_q[`IQC_CFG_Q] +
				{22'h0, wp_q[`IQC_CFG_Q], 2'b00};
			vec_data_d = fail_q ? `IQC_VEC_FAIL : `IQC_VEC_ACK;
		end
		default: vec_wr_d = 1'b0;
		endcase
	end

	always @* begin
		REG_RDATA = cmd_q;
	end

	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			cmd_q <= `IQC_CMD_RESET;
			sel_q <= 9'h000;
			st_q <= ST_IDLE;
			qi_q <= 4'd0;
			arb_q <= 4'd0;
			fail_q <= 1'b0;
			VEC_WR <= 1'b0;
			VEC_ADDR <= 32'h00000000;
			VEC_DATA <= 32'h00000000;
			CFG_BUSY <= 1'b0;
			Q_READY <= 9'h000;
			for (i = 0; i < `IQC_NQ; i = i + 1) begin
				base_q[i] <= 32'h00000000;
				len_q[i] <= 8'h00;
				wp_q[i] <= 8'h00;
			end
		end else begin
			// address and data hold their last value between writes
			VEC_WR <= vec_wr_d;
			if (vec_wr_d) begin
				VEC_ADDR <= vec_addr_d;
				VEC_DATA <= vec_data_d;
			end
			if (cmd_wr)
				cmd_q <= REG_WDATA & `IQC_CMD_RW_MASK;
			if (ar_go) begin
				// capture selectors from the same write
				sel_q <= sel_wr;
				st_q <= ST_LOAD;
				qi_q <= 4'd0;
				fail_q <= 1'b0;
				CFG_BUSY <= 1'b1;
			end
			// bit 0 is never stored, so it self-clears
			case (st_q)
			ST_IDLE: begin
				if (src_hit)
					wp_q[src] <= wp_next(wp_q[src], len_q[src]);
				arb_q <= {1'b0, arb_q[2:0] + 3'd1};
			end
			ST_LOAD: begin
				if (sel_q[qi_q]) begin
					base_q[qi_q] <= base_of(qi_q);
					len_q[qi_q] <= len_of(qi_q);
					wp_q[qi_q] <= 8'h00;
					Q_READY[qi_q] <= len_of(qi_q) != 8'h00;
					if (len_of(qi_q) == 8'h00)
						fail_q <= 1'b1;
				end // unselected queues stay as they are
				if (qi_q == `IQC_CFG_Q)
					st_q <= ST_ACK;
				else
					qi_q <= qi_q + 4'd1;
			end
			ST_ACK: begin
				// ack or fail vector into the config queue
				if (Q_READY[`IQC_CFG_Q])
					wp_q[`IQC_CFG_Q] <= wp_next(wp_q[`IQC_CFG_Q],
						len_q[`IQC_CFG_Q]);
				st_q <= ST_IDLE;
				CFG_BUSY <= 1'b0;
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule

// ---- hw/iqc_consts.vh ----
// constants for the interrupt queue configuration command block
`ifndef IQC_CONSTS_VH
`define IQC_CONSTS_VH
`define IQC_OFF_GLOBAL_COMMAND 8'h00
`define IQC_OFF_IQ_LEN0 8'h0c
`define IQC_OFF_IQ_LEN1 8'h10
`define IQC_OFF_RX_BASE0 8'h14
`define IQC_OFF_TX_BASE0 8'h24
`define IQC_OFF_CFG_BASE 8'h3c
`define IQC_BIT_RX_HI 31
`define IQC_BIT_RX_LO 28
`define IQC_BIT_TX_HI 27
`define IQC_BIT_TX_LO 24
`define IQC_BIT_CFG_SEL 21
`define IQC_BIT_ACTION 0
`define IQC_CMD_RW_MASK 32'hff200000
`define IQC_CMD_RESET 32'h00000000
`define IQC_NQ 9
`define IQC_CFG_Q 8
`define IQC_VEC_ACK 32'h00000001
`define IQC_VEC_FAIL 32'h00000002
`endif

// ---- verification/iqc_queue_config_monitor.sv ----
// checker for the queue configuration command block
`timescale 1ns/10ps
module iqc_monitor (
	input wire CLK_SYS, // clock
	input wire RST_N, // reset
	input wire REG_WR, // write
	input wire [7:0] REG_ADDR, // offset
	input wire [31:0] REG_WDATA, // wdata
	input wire [31:0] REG_RDATA, // rdata
	input wire VEC_WR, // vector write
	input wire [31:0] VEC_DATA, // vector
	input wire CFG_BUSY, // busy
	input wire [8:0] Q_READY // ready
);
	wire st = REG_WR && REG_ADDR == 8'h00 && REG_WDATA[0];
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	AST_RSV: assert property ((REG_RDATA & 32'h00dfffff) == 32'h0)
		else $error("reserved bits set");
	AST_SEL: assert property (REG_WR && REG_ADDR == 8'h00 |=>
		((REG_RDATA ^ $past(REG_WDATA)) & 32'hff200000) == 32'h0)
		else $error("selector not stored");
	AST_IDLE: assert property (!st && !CFG_BUSY |=> !CFG_BUSY)
		else $error("busy without request");
	AST_GO: assert property (st && !CFG_BUSY |=> CFG_BUSY [*8])
		else $error("request not started");
	AST_SPAN: assert property ($rose(CFG_BUSY) |->
		CFG_BUSY [*8] ##[1:4] !CFG_BUSY) else $error("busy span wrong");
	AST_CAUSE: assert property ($rose(CFG_BUSY) |-> $past(st))
		else $error("busy without cause");
	AST_ACK: assert property ($fell(CFG_BUSY) && Q_READY[8] |->
		##[0:2] VEC_WR && VEC_DATA inside {32'h1, 32'h2})
		else $error("no ack vector");
	AST_KEEP: assert property (!CFG_BUSY && !st |=> $stable(Q_READY))
		else $error("queue state changed");
	cover property ($rose(CFG_BUSY));
	cover property (VEC_WR && !CFG_BUSY);
	cover property (st && CFG_BUSY);
endmodule

// ---- verification/iqc_queue_config_tb_top.sv ----
// testbench for the queue configuration command block
`timescale 1ns/10ps
module iqc_queue_config_tb_top;
	logic clk = 0, rst_n = 0, wr = 0;
	logic [31:0] wdata = 0, b[9];
	logic [7:0] addr = 0, qlen_rx = 8'h10;
	logic [3:0] rxv = 0, txv = 0;
	logic [127:0] rxd = 0, txd = 0;
	wire [31:0] rdata, vaddr, vdata;
	wire vwr, busy;
	wire [8:0] qrdy;
	int failures = 0, n_compared = 0;
	iqc_queue_config i_dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_WR(wr),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.BASE_RX0(b[0]), .BASE_RX1(b[1]), .BASE_RX2(b[2]), .BASE_RX3(b[3]),
		.BASE_TX0(b[4]), .BASE_TX1(b[5]), .BASE_TX2(b[6]), .BASE_TX3(b[7]),
		.BASE_CFG(b[8]), .QLEN_RX(qlen_rx), .QLEN_TX(8'h04), .QLEN_CFG(8'h08),
		.RX_VEC_VALID(rxv), .TX_VEC_VALID(txv), .RX_VEC(rxd), .TX_VEC(txd),
		.VEC_WR(vwr), .VEC_ADDR(vaddr), .VEC_DATA(vdata), .CFG_BUSY(busy),
		.Q_READY(qrdy));
	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_cmd(input logic [31:0] d);
		wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk_reset;
		@(negedge clk);
		chk(rdata, 32'h0);
		chk({23'h0, qrdy}, 32'h0);
		chk({31'h0, vwr}, 32'h0);
		@(posedge clk);
	endtask
	task automatic chk_reserved;
		wr_cmd(32'hfffffffe);
		repeat (3) @(negedge clk);
		chk(rdata, 32'hff200000);
		chk({31'h0, busy}, 32'h0);
		chk({23'h0, qrdy}, 32'h0);
		@(posedge clk);
	endtask
	task automatic act(input logic [31:0] d, late, input logic [8:0] q, m,
		input logic [31:0] vec, va);
		wr_cmd(d);
		@(negedge clk);
		chk({31'h0, busy}, 32'h1);
		@(posedge clk);
		if (late) wr_cmd(late);
		repeat (20) begin
			@(negedge clk);
			if (vwr === 1'b1) break;
		end
		chk({31'h0, vwr}, 32'h1);
		chk(vdata, vec);
		chk(vaddr, va);
		chk({23'h0, qrdy & m}, {23'h0, q});
		chk(rdata, (late ? late : d) & 32'hff200000);
		chk({31'h0, busy}, 32'h0);
		@(posedge clk);
	endtask
	task automatic vec(input bit tx, input int ch, input logic [31:0] va);
		rxd[ch*32+:32] <= 32'h5a000000 + ch;
		txd[ch*32+:32] <= 32'h5a000000 + ch;
		if (tx) txv[ch] <= 1'b1;
		else rxv[ch] <= 1'b1;
		repeat (20) begin
			@(negedge clk);
			if (vwr === 1'b1) break;
		end
		chk({31'h0, vwr}, 32'h1);
		chk(vaddr, va);
		chk(vdata, 32'h5a000000 + ch);
		@(posedge clk);
		rxv <= 4'h0;
		txv <= 4'h0;
		@(posedge clk);
	endtask
	task automatic end_sim;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		#20000;
		failures++;
		end_sim;
	end
	initial begin
		for (int i = 0; i < 9; i++) b[i] <= 32'h1000 * (i + 1);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk_reset;
		chk_reserved;
		act(32'h80200001, 0, 9'h108, 9'h1ff, 32'h1, b[8]);
		act(32'h01000001, 32'h10000001, 9'h118, 9'h1ff, 32'h1, b[8] + 4);
		vec(0, 3, b[3]);
		vec(1, 0, b[4]);
		qlen_rx <= 8'h00;
		act(32'h10000001, 0, 9'h118, 9'h1fe, 32'h2, b[8] + 8);
		vec(0, 3, b[3] + 4);
		end_sim;
	end
endmodule
bind iqc_queue_config iqc_monitor i_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .VEC_WR(VEC_WR), .VEC_DATA(VEC_DATA),
	.CFG_BUSY(CFG_BUSY), .Q_READY(Q_READY));
